// ===== logic/vpcr_cfg.svh
// Offsets, field positions, codes and reset values of the video port capture registers
`ifndef VPCR_CFG_SVH
`define VPCR_CFG_SVH

// Memory-mapped register byte addresses
`define VPCR_OFF_BUF_A 16'hFF0C
`define VPCR_OFF_BUF_B 16'hFF10
`define VPCR_OFF_IND_ADDR 16'hFF14
`define VPCR_OFF_IND_DATA 16'hFF18
`define VPCR_OFF_GP_PORT 16'hFF1C
`define VPCR_OFF_SERIAL 16'hFF20
`define VPCR_OFF_WIN_SIZE 16'hFF24
`define VPCR_OFF_DATA_OFS 16'hFF28

// I/O-space aliases of the serial register
`define VPCR_IO_SERIAL_A 8'hE2
`define VPCR_IO_SERIAL_B 8'hE8

// Field positions
`define VPCR_BUF_MSB 21
`define VPCR_IND_ADDR_MSB 20
`define VPCR_IND_KIND_LSB 21
`define VPCR_IND_KIND_MSB 23
`define VPCR_GP_OUT_MSB 3
`define VPCR_GP_IN_LSB 4
`define VPCR_GP_IN_MSB 7
`define VPCR_SER_CLK_DRIVE 0
`define VPCR_SER_DATA_DRIVE 1
`define VPCR_SER_CLK_SENSE 2
`define VPCR_SER_DATA_SENSE 3
`define VPCR_SER_GATE 4
`define VPCR_SER_MIRROR_LSB 8
`define VPCR_LOW_FIELD_MSB 11
`define VPCR_HIGH_FIELD_LSB 16
`define VPCR_HIGH_FIELD_MSB 24

// Transaction kinds towards the codec
`define VPCR_KIND_REG_WRITE 3'h0
`define VPCR_KIND_REG_READ 3'h1
`define VPCR_KIND_DATA_WRITE 3'h6

// Port modes that use the window settings
`define VPCR_MODE_VIDEO16 3'h1
`define VPCR_MODE_VIDEO8 3'h2

// Extra port clock cycles hidden in the offset and width encodings
`define VPCR_HOFF_BIAS 13'h0002
`define VPCR_WIDTH_BIAS 13'h0002

// Reset values
`define VPCR_RST_SERIAL 5'h00
`define VPCR_RST_WORD 32'h00000000

`endif

// ===== logic/vpcr_pkg.sv
// Types shared by the video port capture register block
package vpcr_pkg;

  // Capture window tracker, Gray coded along idle-skip-delay-line
  typedef enum logic [1:0] {
    VPCR_WIN_IDLE = 2'h0,
    VPCR_WIN_SKIP = 2'h1,
    VPCR_WIN_DELAY = 2'h3,
    VPCR_WIN_LINE = 2'h2
  } vpcr_win_e;

  typedef enum logic {
    VPCR_CX_IDLE = 1'h0,
    VPCR_CX_REQ = 1'h1
  } vpcr_cx_e;

  typedef struct packed {
    logic [21:0] buf_a;
    logic [21:0] buf_b;
    logic [20:0] ind_addr;
    logic [2:0] ind_kind;
    logic [31:0] ind_data;
    logic [3:0] gp_out;
    logic [3:0] gp_in;
    logic strobe_n;
    logic [4:0] serial;
    logic [11:0] line_width;
    logic [8:0] win_height;
    logic [11:0] h_offset;
    logic [8:0] v_offset;
    logic [31:0] rdata;
    logic [7:0] io_rdata;
    logic buf_sel;
    vpcr_win_e win;
    logic [12:0] tick_cnt;
    logic [8:0] vskip;
    logic [9:0] line_cnt;
  } vpcr_regs_s;

  typedef struct packed {
    vpcr_cx_e st;
    logic [20:0] addr;
    logic [2:0] kind;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic read_done;
  } vpcr_codec_s;

endpackage

// ===== logic/vpcr_codec_access.sv
// Indirect register and compressed data transactions towards the external codec
`include "vpcr_cfg.svh"

module vpcr_codec_access import vpcr_pkg::*; (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Requests from the register bank
  input wire logic i_start,
  input wire logic i_start_fifo,
  input wire logic [20:0] i_addr,
  input wire logic [2:0] i_kind,
  input wire logic [31:0] i_wdata,
  input wire logic [31:0] i_fifo_data,
  output logic o_busy,
  output logic o_read_done,
  output logic [31:0] o_read_data,
  // Codec side
  output logic o_codec_req,
  output logic [20:0] o_codec_addr,
  output logic [2:0] o_codec_kind,
  output logic [31:0] o_codec_wdata,
  input wire logic i_codec_ack,
  input wire logic [31:0] i_codec_rdata
);

  vpcr_codec_s s_q;
  vpcr_codec_s s_d;

  always_comb begin
    s_d = s_q;
    s_d.read_done = 1'b0;
    case (s_q.st)
      VPCR_CX_IDLE: begin
        if (i_start_fifo) begin
          s_d.st = VPCR_CX_REQ;
          s_d.addr = i_addr;
          s_d.kind = `VPCR_KIND_DATA_WRITE;
          s_d.wdata = i_fifo_data;
        end else if (i_start) begin
          s_d.st = VPCR_CX_REQ;
          s_d.addr = i_addr;
          s_d.kind = i_kind;
          s_d.wdata = i_wdata;
        end
      end
      VPCR_CX_REQ: begin
        if (i_codec_ack) begin
          s_d.st = VPCR_CX_IDLE;
          if (s_q.kind == `VPCR_KIND_REG_READ) begin
            s_d.rdata = i_codec_rdata;
            s_d.read_done = 1'b1;
          end
        end
      end
      default: s_d.st = VPCR_CX_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_busy = (s_q.st == VPCR_CX_REQ);
  assign o_read_done = s_q.read_done;
  assign o_read_data = s_q.rdata;
  assign o_codec_req = (s_q.st == VPCR_CX_REQ);
  assign o_codec_addr = s_q.addr;
  assign o_codec_kind = s_q.kind;
  assign o_codec_wdata = s_q.wdata;

  property p_start_req;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_start && !i_start_fifo && !o_busy) |=> (o_codec_req && o_codec_addr == $past(i_addr)
      && o_codec_kind == $past(i_kind));
  endproperty
  a_start_req: assert property (p_start_req) else $error("indirect request not raised");

  property p_fifo_kind;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_start_fifo && !o_busy) |=> (o_codec_req && o_codec_kind == `VPCR_KIND_DATA_WRITE);
  endproperty
  a_fifo_kind: assert property (p_fifo_kind) else $error("fifo transaction kind wrong");

  property p_req_hold;
    @(posedge i_clk) disable iff (!i_rst_n)
    (o_codec_req && !i_codec_ack) |=> (o_codec_req && $stable(o_codec_kind) && $stable(o_codec_addr)
      && $stable(o_codec_wdata));
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("codec request dropped or changed before acknowledge");

endmodule // vpcr_codec_access

// ===== logic/vpcr_regs.sv
// Video port capture register bank with port strobe, serial pins and capture window
`include "vpcr_cfg.svh"

// Contract
// - First buffer start: 22-bit, 8-byte aligned; bits 2:0 are stored and read back as written
// - Second buffer start for double buffering
// - Indirect address names codec register
// - Kind codes: write, read, data write
// - Fifo writes force data-write kind
// - Data register write starts codec sequence
// - Trigger drives low nibble, pulses strobe
// - Upper nibble latched while strobe low
// - General port exists only on PCI
// - Clock drive bit: 0 low, 1 released
// - Data drive bit: 0 low, 1 released
// - Sense bits report real pin levels
// - Gate bit enables both drive bits
// - Five mirror bits copy low bits
// - Serial register also at I/O ports
// - Height field is lines minus one
// - Window applies only in video modes
// - Line starts offset plus two later
// - Vertical offset skips leading hsyncs
// - Mode codes 001 and 010 are video
module vpcr_regs import vpcr_pkg::*; (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Memory-mapped register port
  input wire logic i_mem_wr,
  input wire logic i_mem_rd,
  input wire logic [15:0] i_mem_addr,
  input wire logic [31:0] i_mem_wdata,
  output logic [31:0] o_mem_rdata,
  // I/O-space byte port
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_addr,
  input wire logic [7:0] i_io_wdata,
  output logic [7:0] o_io_rdata,
  // Configuration and neighbouring controls
  input wire logic i_pci_bus,
  input wire logic [2:0] i_port_mode,
  input wire logic i_double_buffer,
  input wire logic i_strobe_trigger,
  input wire logic i_ofifo_write,
  input wire logic [31:0] i_ofifo_data,
  // Video timing
  input wire logic i_port_tick,
  input wire logic i_hsync,
  input wire logic i_vsync,
  output logic o_capture_pixel,
  output logic o_capture_line_start,
  output logic [21:0] o_capture_base,
  // Port data lines
  input wire logic [7:0] i_port_data_lines,
  output logic [3:0] o_port_data_lines,
  output logic [3:0] o_port_data_lines_oe_n,
  output logic o_port_strobe_n,
  // Serial pins
  input wire logic i_serial_clock,
  input wire logic i_serial_data,
  output logic o_serial_clock,
  output logic o_serial_clock_oe_n,
  output logic o_serial_data,
  output logic o_serial_data_oe_n,
  // Codec side
  output logic o_codec_req,
  output logic [20:0] o_codec_addr,
  output logic [2:0] o_codec_kind,
  output logic [31:0] o_codec_wdata,
  input wire logic i_codec_ack,
  input wire logic [31:0] i_codec_rdata,
  output logic o_codec_busy
);

  vpcr_regs_s s_q;
  vpcr_regs_s s_d;
  logic video_mode;
  logic ind_start;
  logic read_done;
  logic [31:0] read_word;
  logic [31:0] serial_word;
  logic io_hit;

  function automatic logic hit(input logic [15:0] addr, input logic [15:0] off);
    hit = (addr == off);
  endfunction

  function automatic logic [12:0] widen12(input logic [11:0] v);
    widen12 = {1'b0, v};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  assign video_mode = (i_port_mode == `VPCR_MODE_VIDEO16) || (i_port_mode == `VPCR_MODE_VIDEO8);
  assign ind_start = i_mem_wr && hit(i_mem_addr, `VPCR_OFF_IND_DATA);
  assign io_hit = (i_io_addr == `VPCR_IO_SERIAL_A) || (i_io_addr == `VPCR_IO_SERIAL_B);

  always_comb begin
    serial_word = '0;
    serial_word[`VPCR_SER_CLK_DRIVE] = s_q.serial[`VPCR_SER_CLK_DRIVE];
    serial_word[`VPCR_SER_DATA_DRIVE] = s_q.serial[`VPCR_SER_DATA_DRIVE];
    serial_word[`VPCR_SER_CLK_SENSE] = i_serial_clock;
    serial_word[`VPCR_SER_DATA_SENSE] = i_serial_data;
    serial_word[`VPCR_SER_GATE] = s_q.serial[`VPCR_SER_GATE];
    serial_word[`VPCR_SER_MIRROR_LSB +: 5] = serial_word[4:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_d = s_q;
    s_d.strobe_n = 1'b1;

    // Register writes, memory side and I/O side
    if (i_mem_wr) begin
      if (hit(i_mem_addr, `VPCR_OFF_BUF_A)) begin
        s_d.buf_a = i_mem_wdata[`VPCR_BUF_MSB:0];
      end else if (hit(i_mem_addr, `VPCR_OFF_BUF_B)) begin
        s_d.buf_b = i_mem_wdata[`VPCR_BUF_MSB:0];
      end else if (hit(i_mem_addr, `VPCR_OFF_IND_ADDR)) begin
        s_d.ind_addr = i_mem_wdata[`VPCR_IND_ADDR_MSB:0];
        s_d.ind_kind = i_mem_wdata[`VPCR_IND_KIND_MSB:`VPCR_IND_KIND_LSB];
      end else if (hit(i_mem_addr, `VPCR_OFF_IND_DATA)) begin
        s_d.ind_data = i_mem_wdata;
      end else if (hit(i_mem_addr, `VPCR_OFF_GP_PORT) && i_pci_bus) begin
        s_d.gp_out = i_mem_wdata[`VPCR_GP_OUT_MSB:0];
      end else if (hit(i_mem_addr, `VPCR_OFF_SERIAL)) begin
        s_d.serial = {i_mem_wdata[`VPCR_SER_GATE], 2'b00, i_mem_wdata[1:0]};
      end else if (hit(i_mem_addr, `VPCR_OFF_WIN_SIZE)) begin
        s_d.line_width = i_mem_wdata[`VPCR_LOW_FIELD_MSB:0];
        s_d.win_height = i_mem_wdata[`VPCR_HIGH_FIELD_MSB:`VPCR_HIGH_FIELD_LSB];
      end else if (hit(i_mem_addr, `VPCR_OFF_DATA_OFS)) begin
        s_d.h_offset = i_mem_wdata[`VPCR_LOW_FIELD_MSB:0];
        s_d.v_offset = i_mem_wdata[`VPCR_HIGH_FIELD_MSB:`VPCR_HIGH_FIELD_LSB];
      end
    end
    if (i_io_wr && io_hit) begin
      s_d.serial = {i_io_wdata[`VPCR_SER_GATE], 2'b00, i_io_wdata[1:0]};
    end

    if (read_done) begin
      s_d.ind_data = read_word;
    end

    if (i_strobe_trigger && i_pci_bus) begin
      s_d.strobe_n = 1'b0;
    end
    if (!s_q.strobe_n) begin
      s_d.gp_in = i_port_data_lines[`VPCR_GP_IN_MSB:`VPCR_GP_IN_LSB];
    end

    // Register reads, data returned next cycle
    // reserved bits zero
    if (i_mem_rd) begin
      if (hit(i_mem_addr, `VPCR_OFF_BUF_A)) begin
        s_d.rdata = {10'h000, s_q.buf_a};
      end else if (hit(i_mem_addr, `VPCR_OFF_BUF_B)) begin
        s_d.rdata = {10'h000, s_q.buf_b};
      end else if (hit(i_mem_addr, `VPCR_OFF_IND_ADDR)) begin
        s_d.rdata = {8'h00, s_q.ind_kind, s_q.ind_addr};
      end else if (hit(i_mem_addr, `VPCR_OFF_IND_DATA)) begin
        s_d.rdata = s_q.ind_data;
      end else if (hit(i_mem_addr, `VPCR_OFF_GP_PORT) && i_pci_bus) begin
        s_d.rdata = {24'h000000, s_q.gp_in, s_q.gp_out};
      end else if (hit(i_mem_addr, `VPCR_OFF_SERIAL)) begin
        s_d.rdata = serial_word;
      end else if (hit(i_mem_addr, `VPCR_OFF_WIN_SIZE)) begin
        s_d.rdata = {7'h00, s_q.win_height, 4'h0, s_q.line_width};
      end else if (hit(i_mem_addr, `VPCR_OFF_DATA_OFS)) begin
        s_d.rdata = {7'h00, s_q.v_offset, 4'h0, s_q.h_offset};
      end else begin
        s_d.rdata = `VPCR_RST_WORD;
      end
    end
    if (i_io_rd) begin
      s_d.io_rdata = io_hit ? serial_word[7:0] : 8'h00;
    end

    // Buffer alternation at each frame
    if (i_vsync) begin
      s_d.buf_sel = i_double_buffer ? !s_q.buf_sel : 1'b0;
    end

    // Capture window tracker
    case (s_q.win)
      VPCR_WIN_IDLE: begin
        if (i_vsync && video_mode) begin
          s_d.win = VPCR_WIN_SKIP;
          s_d.vskip = s_q.v_offset;
          s_d.line_cnt = '0;
        end
      end
      VPCR_WIN_SKIP: begin
        if (i_hsync) begin
          if (s_q.vskip != 9'h000) begin
            s_d.vskip = s_q.vskip - 9'h001;
          end else if (s_q.line_cnt > {1'b0, s_q.win_height}) begin
            s_d.win = VPCR_WIN_IDLE;
          end else begin
            s_d.win = VPCR_WIN_DELAY;
            s_d.tick_cnt = widen12(s_q.h_offset) + `VPCR_HOFF_BIAS;
          end
        end
      end
      VPCR_WIN_DELAY: begin
        if (i_port_tick) begin
          if (s_q.tick_cnt == 13'h0001) begin
            s_d.win = VPCR_WIN_LINE;
            s_d.tick_cnt = widen12(s_q.line_width) + `VPCR_WIDTH_BIAS;
          end else begin
            s_d.tick_cnt = s_q.tick_cnt - 13'h0001;
          end
        end
      end
      VPCR_WIN_LINE: begin
        if (i_port_tick) begin
          if (s_q.tick_cnt == 13'h0001) begin
            s_d.win = VPCR_WIN_SKIP;
            s_d.line_cnt = s_q.line_cnt + 10'h001;
          end else begin
            s_d.tick_cnt = s_q.tick_cnt - 13'h0001;
          end
        end
      end
      default: s_d.win = VPCR_WIN_IDLE;
    endcase
    if (!video_mode) begin
      s_d.win = VPCR_WIN_IDLE;
    end else if (i_vsync) begin
      s_d.win = VPCR_WIN_SKIP;
      s_d.vskip = s_q.v_offset;
      s_d.line_cnt = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s_q <= '0;
      s_q.strobe_n <= 1'b1;
      s_q.serial <= `VPCR_RST_SERIAL;
      s_q.win <= VPCR_WIN_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Codec sequencer

  vpcr_codec_access u_codec (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_start(ind_start),
    .i_start_fifo(i_ofifo_write),
    .i_addr(s_q.ind_addr),
    .i_kind(s_q.ind_kind),
    .i_wdata(i_mem_wdata),
    .i_fifo_data(i_ofifo_data),
    .o_busy(o_codec_busy),
    .o_read_done(read_done),
    .o_read_data(read_word),
    .o_codec_req(o_codec_req),
    .o_codec_addr(o_codec_addr),
    .o_codec_kind(o_codec_kind),
    .o_codec_wdata(o_codec_wdata),
    .i_codec_ack(i_codec_ack),
    .i_codec_rdata(i_codec_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign o_mem_rdata = s_q.rdata;
  assign o_io_rdata = s_q.io_rdata;
  assign o_port_strobe_n = s_q.strobe_n;
  assign o_port_data_lines = s_q.gp_out;
  assign o_port_data_lines_oe_n = {4{s_q.strobe_n}};
  assign o_serial_clock = 1'b0;
  assign o_serial_clock_oe_n = !(s_q.serial[`VPCR_SER_GATE] && !s_q.serial[`VPCR_SER_CLK_DRIVE]);
  assign o_serial_data = 1'b0;
  assign o_serial_data_oe_n = !(s_q.serial[`VPCR_SER_GATE] && !s_q.serial[`VPCR_SER_DATA_DRIVE]);
  assign o_capture_pixel = video_mode ? (s_q.win == VPCR_WIN_LINE) && i_port_tick : i_port_tick;
  assign o_capture_line_start = (s_q.win == VPCR_WIN_DELAY) && (s_d.win == VPCR_WIN_LINE);
  assign o_capture_base = s_q.buf_sel ? s_q.buf_b : s_q.buf_a;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_strobe;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_strobe_trigger && i_pci_bus) |=> (!o_port_strobe_n && o_port_data_lines_oe_n == 4'h0) ##1 o_port_strobe_n;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe not pulsed");

  property p_latch;
    @(posedge i_clk) disable iff (!i_rst_n)
    !o_port_strobe_n |=> s_q.gp_in == $past(i_port_data_lines[7:4]);
  endproperty
  a_latch: assert property (p_latch) else $error("input nibble not latched");

  property p_pci_only;
    @(posedge i_clk) disable iff (!i_rst_n)
    !i_pci_bus |=> !$fell(o_port_strobe_n);
  endproperty
  a_pci_only: assert property (p_pci_only) else $error("strobe without PCI");

  property p_gate;
    @(posedge i_clk) disable iff (!i_rst_n)
    !s_q.serial[4] |-> o_serial_clock_oe_n && o_serial_data_oe_n;
  endproperty
  a_gate: assert property (p_gate) else $error("serial pin driven while gated");

  property p_sense;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_mem_rd && i_mem_addr == `VPCR_OFF_SERIAL) |=> o_mem_rdata[3] == $past(i_serial_data)
      && o_mem_rdata[2] == $past(i_serial_clock)
      && o_mem_rdata[12:8] == o_mem_rdata[4:0];
  endproperty
  a_sense: assert property (p_sense) else $error("serial read back wrong");

  property p_readback;
    @(posedge i_clk) disable iff (!i_rst_n)
    read_done |=> s_q.ind_data == $past(read_word);
  endproperty
  a_readback: assert property (p_readback) else $error("codec read word lost");

  property p_mode;
    @(posedge i_clk) disable iff (!i_rst_n)
    !video_mode |=> s_q.win == VPCR_WIN_IDLE || video_mode;
  endproperty
  a_mode: assert property (p_mode) else $error("window active outside video mode");

endmodule // vpcr_regs

// ===== sim/vpcr_codec_model.sv
// Behavioural codec and port-latch partner of the capture register block
module vpcr_codec_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Codec requests
  input wire logic i_req,
  input wire logic [20:0] i_addr,
  input wire logic [2:0] i_kind,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_delay,
  input wire logic [31:0] i_reply,
  output logic o_ack,
  output logic [31:0] o_rdata,
  output logic [20:0] o_seen_addr,
  output logic [2:0] o_seen_kind,
  output logic [31:0] o_seen_wdata,
  // Port latch
  input wire logic i_strobe_n,
  input wire logic [3:0] i_nibble,
  output logic [3:0] o_upper
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q;

  ////////////////////////////////////////////////////////////
  // answer each request after a set delay
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !i_req || o_ack) begin
      o_ack <= 1'b0;
      wait_q <= 4'h0;
    end else if (wait_q == i_delay) begin
      o_ack <= 1'b1;
      o_seen_addr <= i_addr;
      o_seen_kind <= i_kind;
      o_seen_wdata <= i_wdata;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end

  // reply word valid only with the acknowledge
  assign o_rdata = o_ack ? i_reply : ~i_reply;

  // upper lines carry the nibble while the strobe is low, its inverse while high
  assign o_upper = i_strobe_n ? ~i_nibble : i_nibble;
endmodule // vpcr_codec_model

// ===== sim/vpcr_regs_test.sv
// Self-checking bench of the video port capture register block
`include "vpcr_cfg.svh"

module vpcr_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0, i_rst_n = 1'b0, i_mem_wr = 1'b0, i_mem_rd = 1'b0, i_io_wr = 1'b0, i_io_rd = 1'b0;
  logic i_pci_bus = 1'b1, i_double_buffer = 1'b1, i_strobe_trigger = 1'b0, i_ofifo_write = 1'b0;
  logic i_port_tick = 1'b1, i_hsync = 1'b0, i_vsync = 1'b0, ext_clock_rel = 1'b1;
  logic [2:0] i_port_mode = 3'h0, kind;
  logic [3:0] delay = 4'h0;
  logic [7:0] i_io_addr = 8'h00, i_io_wdata = 8'h00;
  logic [15:0] i_mem_addr = 16'h0000;
  logic [20:0] ca;
  logic [31:0] i_mem_wdata = 32'h00000000, i_ofifo_data = 32'h00000000;
  logic [7:0] ser_w [4] = '{8'h10, 8'h13, 8'h11, 8'h03};
  logic [7:0] ser_r [4] = '{8'h10, 8'h1F, 8'h15, 8'h0F};
  wire logic [7:0] i_port_data_lines;
  wire logic i_serial_clock, i_serial_data, i_codec_ack;
  wire logic [31:0] i_codec_rdata, seen_wdata;
  wire logic [20:0] seen_addr;
  wire logic [2:0] seen_kind;
  wire logic [3:0] upper;
  logic [31:0] o_mem_rdata, o_codec_wdata;
  logic [7:0] o_io_rdata;
  logic o_capture_pixel, o_capture_line_start, o_port_strobe_n, o_serial_clock, o_serial_clock_oe_n;
  logic o_serial_data, o_serial_data_oe_n, o_codec_req, o_codec_busy;
  logic [21:0] o_capture_base;
  logic [3:0] o_port_data_lines, o_port_data_lines_oe_n;
  logic [20:0] o_codec_addr;
  logic [2:0] o_codec_kind;
  int fails = 0, samples_checked = 0, pix, starts;

  always #10 i_clk = ~i_clk;

  // Open-drain serial lines with pull-ups, port data lines looped back
  assign i_serial_clock = (o_serial_clock_oe_n | o_serial_clock) & ext_clock_rel;
  assign i_serial_data = o_serial_data_oe_n | o_serial_data;
  assign i_port_data_lines = {upper, o_port_data_lines ^ o_port_data_lines_oe_n};

  vpcr_regs dut (.i_clk, .i_rst_n, .i_mem_wr, .i_mem_rd, .i_mem_addr, .i_mem_wdata, .o_mem_rdata,
    .i_io_wr, .i_io_rd, .i_io_addr, .i_io_wdata, .o_io_rdata, .i_pci_bus, .i_port_mode, .i_double_buffer,
    .i_strobe_trigger, .i_ofifo_write, .i_ofifo_data, .i_port_tick, .i_hsync, .i_vsync, .o_capture_pixel,
    .o_capture_line_start, .o_capture_base, .i_port_data_lines, .o_port_data_lines, .o_port_data_lines_oe_n,
    .o_port_strobe_n, .i_serial_clock, .i_serial_data, .o_serial_clock, .o_serial_clock_oe_n, .o_serial_data,
    .o_serial_data_oe_n, .o_codec_req, .o_codec_addr, .o_codec_kind, .o_codec_wdata, .i_codec_ack,
    .i_codec_rdata, .o_codec_busy);

  vpcr_codec_model codec (.i_clk, .i_rst_n, .i_req(o_codec_req), .i_addr(o_codec_addr), .i_kind(o_codec_kind),
    .i_wdata(o_codec_wdata), .i_delay(delay), .i_reply(32'hC0DE1234), .o_ack(i_codec_ack),
    .o_rdata(i_codec_rdata), .o_seen_addr(seen_addr), .o_seen_kind(seen_kind), .o_seen_wdata(seen_wdata),
    .i_strobe_n(o_port_strobe_n), .i_nibble(4'hA), .o_upper(upper));

  ////////////////////////////////////////////////////////////
  task automatic results();
    if (fails == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_mem_wr <= 1'b1;
    i_mem_addr <= a;
    i_mem_wdata <= d;
    @(posedge i_clk);
    i_mem_wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] e, input string name);
    @(posedge i_clk);
    i_mem_rd <= 1'b1;
    i_mem_addr <= a;
    @(posedge i_clk);
    i_mem_rd <= 1'b0;
    #1;
    chk(name, e, o_mem_rdata);
  endtask

  task automatic iowr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_io_wr <= 1'b1;
    i_io_addr <= a;
    i_io_wdata <= d;
    @(posedge i_clk);
    i_io_wr <= 1'b0;
  endtask

  task automatic iord(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_io_rd <= 1'b1;
    i_io_addr <= a;
    @(posedge i_clk);
    i_io_rd <= 1'b0;
    #1;
    chk("io_read", {24'h000000, e}, {24'h000000, o_io_rdata});
  endtask

  task automatic idle();
    int n;
    n = 0;
    while (o_codec_busy !== 1'b0 && n < 64) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    if (n == 64) begin
      fails++;
      results();
    end
  endtask

  task automatic trig();
    @(posedge i_clk);
    i_strobe_trigger <= 1'b1;
    @(posedge i_clk);
    i_strobe_trigger <= 1'b0;
    #1;
  endtask

  task automatic sync(input logic v);
    @(posedge i_clk);
    i_vsync <= v;
    i_hsync <= !v;
    @(posedge i_clk);
    i_vsync <= 1'b0;
    i_hsync <= 1'b0;
    #1;
  endtask

  task automatic count(input int n);
    repeat (n) begin
      @(posedge i_clk);
      #1;
      if (o_capture_pixel === 1'b1) pix++;
      if (o_capture_line_start === 1'b1) starts++;
    end
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(16'hFF20, 32'h00000C0C, "serial_reset");
    wr(16'hFF0C, 32'hFFFFFFFF);
    rd(16'hFF0C, 32'h003FFFFF, "buf_a");
    wr(16'hFF10, 32'h12345678);
    rd(16'hFF10, 32'h00345678, "buf_b");
    wr(16'hFF2C, 32'hFFFFFFFF);
    rd(16'hFF2C, 32'h00000000, "unmapped");
    wr(16'hFF14, 32'hFFFFFFFF);
    rd(16'hFF14, 32'h00FFFFFF, "ind_addr");
    for (int k = 0; k < 2; k++) begin
      delay <= k ? 4'h6 : 4'h0;
      kind = k ? `VPCR_KIND_REG_READ : `VPCR_KIND_REG_WRITE;
      ca = 21'h0ABCD0 | 21'(k);
      wr(16'hFF14, {8'h00, kind, ca});
      wr(16'hFF18, 32'h5A5A0000 | k);
      #1;
      chk("codec_busy", 32'h1, {31'h0, o_codec_busy});
      idle();
      chk("codec_kind", {29'h0, kind}, {29'h0, seen_kind});
      chk("codec_addr", {11'h000, ca}, {11'h000, seen_addr});
      chk("codec_wdata", 32'h5A5A0000 | k, seen_wdata);
    end
    rd(16'hFF18, 32'hC0DE1234, "read_word");
    @(posedge i_clk);
    i_ofifo_write <= 1'b1;
    i_ofifo_data <= 32'h600DF00D;
    @(posedge i_clk);
    i_ofifo_write <= 1'b0;
    #1;
    idle();
    chk("fifo_kind", {29'h0, `VPCR_KIND_DATA_WRITE}, {29'h0, seen_kind});
    chk("fifo_wdata", 32'h600DF00D, seen_wdata);
    wr(16'hFF1C, 32'hFFFFFFF5);
    trig();
    chk("strobe", {1'b0, 4'h0, 4'h5}, {o_port_strobe_n, o_port_data_lines_oe_n, o_port_data_lines});
    @(posedge i_clk);
    #1;
    chk("strobe_end", 32'h1, {31'h0, o_port_strobe_n});
    rd(16'hFF1C, 32'h000000A5, "gp_port");
    @(posedge i_clk) i_pci_bus <= 1'b0;
    rd(16'hFF1C, 32'h00000000, "gp_absent");
    trig();
    chk("strobe_absent", 32'h1, {31'h0, o_port_strobe_n});
    @(posedge i_clk) i_pci_bus <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(16'hFF20, 32'hFFFFFFEC | {24'h0, ser_w[i]});
      rd(16'hFF20, {16'h0000, ser_r[i], ser_r[i]}, "serial");
    end
    @(posedge i_clk) ext_clock_rel <= 1'b0;
    rd(16'hFF20, 32'h00000B0B, "serial_sense");
    @(posedge i_clk) ext_clock_rel <= 1'b1;
    iord(`VPCR_IO_SERIAL_A, 8'h0F);
    iowr(`VPCR_IO_SERIAL_B, 8'h10);
    iord(`VPCR_IO_SERIAL_B, 8'h10);
    chk("clk_oe_n", 32'h0, {31'h0, o_serial_clock_oe_n});
    wr(16'hFF24, 32'hFE00F002);
    wr(16'hFF28, 32'hFE01F001);
    rd(16'hFF24, 32'h00000002, "win_size");
    rd(16'hFF28, 32'h00010001, "data_ofs");
    for (int m = 0; m < 3; m++) begin
      @(posedge i_clk) i_port_mode <= m == 0 ? `VPCR_MODE_VIDEO16 : m == 1 ? `VPCR_MODE_VIDEO8 : 3'h0;
      // Eight pixels: one tick each in video16, two in video8
      wr(16'hFF24, m == 1 ? 32'h0000000E : 32'h00000006);
      sync(1'b1);
      if (m < 2) chk("capture_base", m ? 32'h003FFFFF : 32'h00345678, {10'h000, o_capture_base});
      for (int h = 0; h < 4; h++) begin
        pix = 0;
        starts = 0;
        count(20);
        chk("pixels", m < 2 ? (h == 2 ? (m ? 16 : 8) : 0) : 20, pix);
        chk("line_starts", (m < 2 && h == 2) ? 1 : 0, starts);
        sync(1'b0);
      end
    end
    results();
  end
endmodule // vpcr_regs_test
